// [rtl/tmi_regs.svh]
// register map, field positions and reset values of the thermal
// interrupt status and mask block
// assumes: included by bare name; apb byte address is four times the index
`ifndef TMI_REGS_SVH
`define TMI_REGS_SVH

// ==========================================================================
// register indices and byte addresses
`define TMI_IDX_CONFIG       8'h40
`define TMI_IDX_STATUS       8'h41
`define TMI_IDX_MASK         8'h43
`define TMI_IDX_MIRROR       8'h4C
`define TMI_BYTE_ADDR(i)     ({2'b00, (i), 2'b00})

// ==========================================================================
// configuration fields
`define TMI_CFG_SOFTRST      4
`define TMI_CFG_FANOFF       5
`define TMI_CFG_POLFLIP      6
`define TMI_CFG_DUALDIODE    7
`define TMI_CFG_WR_BITS      8'hEF

// ==========================================================================
// status and mask fields, shared layout
`define TMI_ST_INTTEMP       0
`define TMI_ST_REM2LIM       1
`define TMI_ST_REM2FLT       2
`define TMI_ST_RSVD          3
`define TMI_ST_GENIN         4
`define TMI_ST_REM1LIM       5
`define TMI_ST_OVTEXT        6
`define TMI_ST_REM1FLT       7
`define TMI_STICKY_BITS      8'hE7
`define TMI_MASK_WR_BITS     8'hF7

// ==========================================================================
// reset values
`define TMI_CONFIG_RESET     8'h20
`define TMI_STATUS_RESET     8'h00
`define TMI_MASK_RESET       8'h00
`define TMI_PIN_SYNC_RESET   2'h1

`endif

// [rtl/tmi_pkg.sv]
// types of the thermal interrupt status and mask block
// assumes: constants come from tmi_regs.svh, not from here
package tmi_pkg;

  // ========================================================================
  // bus answer state, gray along idle -> answer
  typedef enum logic [1:0] {
    TMI_BUS_IDLE   = 2'b00,
    TMI_BUS_ANSWER = 2'b01
  } tmi_bus_state_t;

  typedef logic [7:0] tmi_byte_t;

endpackage

// [rtl/tmi_flag_if.sv]
// carrier between the top and its bank of sticky flags
// assumes: owner and bank share one clock
`timescale 1ns/100ps
`default_nettype none

interface tmi_flag_if #(
  parameter int N = 8
);
  logic [N-1:0] setVec;
  logic [N-1:0] clearVec;
  logic         restore;
  logic [N-1:0] flags;

  modport owner (output setVec, output clearVec, output restore,
                 input flags);
  modport bank  (input setVec, input clearVec, input restore,
                 output flags);
endinterface

`default_nettype wire

// [rtl/tmi_sync.sv]
// two-flop synchroniser for asynchronous pin levels
// assumes: inputs are slow levels, not pulses shorter than two clocks
`timescale 1ns/100ps
`default_nettype none

module tmi_sync #(
  parameter int             W         = 1,
  parameter logic [W-1:0]   RESET_VAL = '0
) (
  input  wire logic         clk,     // block clock
  input  wire logic         rst_n,   // synchronous reset, active low
  input  wire logic [W-1:0] asyncIn, // pin levels
  output var  logic [W-1:0] syncOut  // levels on clk
);

  logic [W-1:0] stage1_q;
  logic [W-1:0] stage1_d;
  logic [W-1:0] syncOut_d;

  // ========================================================================
  // stage one is read only by stage two
  always_comb begin
    stage1_d  = asyncIn;
    syncOut_d = stage1_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_q <= RESET_VAL;
      syncOut  <= RESET_VAL;
    end else begin
      stage1_q <= stage1_d;
      syncOut  <= syncOut_d;
    end
  end

endmodule

`default_nettype wire

// [rtl/tmi_flag_bank.sv]
// bank of sticky flags: set by events, cleared one by one, restorable
// assumes: owner drives set, clear and restore on the same clock
`timescale 1ns/100ps
`default_nettype none

module tmi_flag_bank #(
  parameter int           N         = 8,
  parameter logic [N-1:0] RESET_VAL = '0
) (
  input  wire logic clk,     // block clock
  input  wire logic rst_n,   // synchronous reset, active low
  tmi_flag_if.bank  port     // set, clear, restore and flags
);

  logic [N-1:0] flags_q;
  logic [N-1:0] flags_d;

  // ========================================================================
  // restore beats everything; an event beats a clear in the same cycle
  always_comb begin
    if (port.restore) begin
      flags_d = RESET_VAL;
    end else begin
      flags_d = (flags_q & ~port.clearVec) | port.setVec;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flags_q <= RESET_VAL;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign port.flags = flags_q;

endmodule

`default_nettype wire

// [rtl/tmi_irq_top.sv]
// thermal monitor interrupt status and mask block, top level
// assumes: apb master and comparator flags on clk; input pin and
// overload line arrive asynchronously and are synchronised here
//
// What this block does
// - internal sensor limit violation sets status bit 0.
// - second remote channel limit violation sets status bit 1.
// - short or open on second remote diode sets status bit 2.
// - first remote channel limit violation sets status bit 5.
// - overload line asserted by an outside source sets status bit 6.
// - short or open on first remote diode sets status bit 7.
// - status bit 4 shows input pin, inverted when config bit 6 set.
// - reading status never clears the input status bit.
// - a mask bit of one keeps its status bit off the interrupt.
// - mask register at index 0x43, all zeros after reset.
// - soft restore bit returns config, status, mirror, mask to defaults.
// - polarity flip bit 6 inverts the input for level and interrupt.
//
// Our own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "tmi_regs.svh"

module tmi_irq_top (
  input  wire logic        clk,             // 10 MHz block clock
  input  wire logic        rst_n,           // synchronous reset, low
  // apb slave
  input  wire logic [11:0] paddr,           // byte address
  input  wire logic        psel,            // slave select
  input  wire logic        penable,         // access phase
  input  wire logic        pwrite,          // 1 write, 0 read
  input  wire logic [31:0] pwdata,          // write data
  input  wire logic [3:0]  pstrb,           // byte lanes, lane 0 used
  output var  logic [31:0] prdata,          // read data
  output var  logic        pready,          // transfer done
  output var  logic        pslverr,         // unmapped address
  // condition inputs from comparators, same clock
  input  wire logic        intTempLimitHit, // on-chip limit violated
  input  wire logic        remote1LimitHit, // first remote limit hit
  input  wire logic        remote2LimitHit, // second remote limit hit
  input  wire logic        remote1FaultHit, // first diode short/open
  input  wire logic        remote2FaultHit, // second diode short/open
  input  wire logic        overtempOwnDrive,// device pulls line itself
  // pins
  input  wire logic        generalInputPin, // general input, async
  input  wire logic        overtempLineN,   // overload line, low active
  // outputs
  output var  logic        intN,            // interrupt, active low
  output var  logic        irq,             // interrupt, active high
  output var  logic        fanOffFloat,     // config fan-off bit
  output var  logic        dualDiodeMode,   // config dual-diode bit
  output var  logic        polarityFlip     // config input flip bit
);

  // ========================================================================
  // declarations
  logic [1:0]              pinSync;
  logic                    genInSync;
  logic                    overtempSyncN;

  logic [1:0]              ownHist_q;
  logic [1:0]              ownHist_d;
  logic                    overtempExternal;

  tmi_pkg::tmi_byte_t      config_q;
  tmi_pkg::tmi_byte_t      config_d;
  tmi_pkg::tmi_byte_t      mask_q;
  tmi_pkg::tmi_byte_t      mask_d;
  logic                    restore;

  tmi_pkg::tmi_byte_t      eventVec;
  tmi_pkg::tmi_byte_t      clearVec;
  tmi_pkg::tmi_byte_t      statusView;
  tmi_pkg::tmi_byte_t      pending;
  logic                    genInLive;
  logic                    pendingAny;

  tmi_pkg::tmi_bus_state_t busState_q;
  tmi_pkg::tmi_bus_state_t busState_d;
  logic [31:0]             prdata_d;
  logic                    pready_d;
  logic                    pslverr_d;
  logic                    hitConfig;
  logic                    hitStatus;
  logic                    hitMask;
  logic                    hitMirror;
  logic                    hitAny;
  tmi_pkg::tmi_byte_t      readByte;
  logic                    xferDone;
  logic                    wrEn;
  logic                    cfgWr;
  logic                    statusWr;
  logic                    maskWr;

  logic                    irq_d;
  logic                    intN_d;

  tmi_flag_if #(.N(8)) flagIf ();

  // ========================================================================
  // pin synchronisers
  // the overload line idles high, so its stage resets to one
  tmi_sync #(
    .W         (2),
    .RESET_VAL (`TMI_PIN_SYNC_RESET)
  ) uPinSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({generalInputPin, overtempLineN}),
    .syncOut (pinSync)
  );

  assign genInSync     = pinSync[1];
  assign overtempSyncN = pinSync[0];

  // ========================================================================
  // own-drive history
  // the pin is seen two clocks late, so the device's own drive is
  // remembered that long; otherwise its release would look external
  always_comb begin
    ownHist_d = {ownHist_q[0], overtempOwnDrive};
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ownHist_q <= 2'h0;
    end else begin
      ownHist_q <= ownHist_d;
    end
  end

  assign overtempExternal = !overtempSyncN && !overtempOwnDrive &&
                            !(|ownHist_q);

  // ========================================================================
  // register decode
  assign hitConfig = (paddr == `TMI_BYTE_ADDR(`TMI_IDX_CONFIG));
  assign hitStatus = (paddr == `TMI_BYTE_ADDR(`TMI_IDX_STATUS));
  assign hitMask   = (paddr == `TMI_BYTE_ADDR(`TMI_IDX_MASK));
  assign hitMirror = (paddr == `TMI_BYTE_ADDR(`TMI_IDX_MIRROR));
  assign hitAny    = hitConfig || hitStatus || hitMask || hitMirror;

  // a write lands at the edge that completes the access phase
  assign xferDone = (busState_q == tmi_pkg::TMI_BUS_ANSWER) &&
                    psel && penable;
  // only lane 0 carries a register byte; a write without it is dropped
  assign wrEn     = xferDone && pwrite && pstrb[0];
  assign cfgWr    = wrEn && hitConfig;
  assign statusWr = wrEn && hitStatus;
  assign maskWr   = wrEn && hitMask;

  // ========================================================================
  // configuration register
  // the restore bit never stores: it fires one restore and reads zero
  always_comb begin
    config_d = config_q;
    restore  = 1'b0;
    if (cfgWr) begin
      if (pwdata[`TMI_CFG_SOFTRST]) begin
        restore = 1'b1;
      end else begin
        config_d = pwdata[7:0] & `TMI_CFG_WR_BITS;
      end
    end
    if (restore) begin
      config_d = `TMI_CONFIG_RESET;
    end
    // any assertion of the overload line forces the fan-off bit
    if (!overtempSyncN) begin
      config_d[`TMI_CFG_FANOFF] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      config_q <= `TMI_CONFIG_RESET;
    end else begin
      config_q <= config_d;
    end
  end

  // ========================================================================
  // mask register
  // software keeps a noisy source masked until its cause is gone
  always_comb begin
    mask_d = mask_q;
    if (restore) begin
      mask_d = `TMI_MASK_RESET;
    end else if (maskWr) begin
      mask_d = pwdata[7:0] & `TMI_MASK_WR_BITS;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mask_q <= `TMI_MASK_RESET;
    end else begin
      mask_q <= mask_d;
    end
  end

  // ========================================================================
  // sticky event flags
  // conditions are levels; a flag keeps setting while its cause stays
  always_comb begin
    eventVec = 8'h00;
    eventVec[`TMI_ST_INTTEMP] = intTempLimitHit;
    eventVec[`TMI_ST_REM2LIM] = remote2LimitHit;
    eventVec[`TMI_ST_REM2FLT] = remote2FaultHit;
    eventVec[`TMI_ST_REM1LIM] = remote1LimitHit;
    eventVec[`TMI_ST_OVTEXT]  = overtempExternal;
    eventVec[`TMI_ST_REM1FLT] = remote1FaultHit;
  end

  always_comb begin
    clearVec = 8'h00;
    if (statusWr) begin
      clearVec = pwdata[7:0] & `TMI_STICKY_BITS;
    end
  end

  assign flagIf.setVec   = eventVec & `TMI_STICKY_BITS;
  assign flagIf.clearVec = clearVec;
  assign flagIf.restore  = restore;

  tmi_flag_bank #(
    .N         (8),
    .RESET_VAL (`TMI_STATUS_RESET)
  ) uFlagBank (
    .clk   (clk),
    .rst_n (rst_n),
    .port  (flagIf)
  );

  // ========================================================================
  // status view and interrupt
  // the input bit is a live level, so a read or a write cannot clear it
  assign genInLive = genInSync ^ config_q[`TMI_CFG_POLFLIP];

  always_comb begin
    // bit 3 has no source, so it always reads zero
    statusView = flagIf.flags & `TMI_STICKY_BITS;
    statusView[`TMI_ST_GENIN] = genInLive;
  end

  assign pending    = statusView & ~mask_q;
  assign pendingAny = |pending;

  always_comb begin
    irq_d  = pendingAny;
    intN_d = !pendingAny;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq  <= 1'b0;
      intN <= 1'b1;
    end else begin
      irq  <= irq_d;
      intN <= intN_d;
    end
  end

  // ========================================================================
  // apb answer
  // read data is captured at the setup edge so prdata is a flop; the
  // price is a view one cycle older than the completing edge
  always_comb begin
    readByte = 8'h00;
    if (hitConfig) begin
      readByte = config_q;
    end else if (hitStatus || hitMirror) begin
      readByte = statusView;
    end else if (hitMask) begin
      readByte = mask_q;
    end
  end

  always_comb begin
    busState_d = busState_q;
    prdata_d   = prdata;
    pready_d   = 1'b0;
    pslverr_d  = 1'b0;
    case (busState_q)
      tmi_pkg::TMI_BUS_IDLE: begin
        if (psel && !penable) begin
          busState_d = tmi_pkg::TMI_BUS_ANSWER;
          pready_d   = 1'b1;
          pslverr_d  = !hitAny;
          prdata_d   = pwrite ? 32'h0000_0000 :
                                {24'h00_0000, readByte};
        end
      end
      tmi_pkg::TMI_BUS_ANSWER: begin
        if (psel && penable) begin
          busState_d = tmi_pkg::TMI_BUS_IDLE;
          prdata_d   = 32'h0000_0000;
        end else if (!psel) begin
          // master gave up before access: drop the stale answer
          busState_d = tmi_pkg::TMI_BUS_IDLE;
          prdata_d   = 32'h0000_0000;
        end else begin
          // master has not entered access yet: keep the answer up
          pready_d  = pready;
          pslverr_d = pslverr;
        end
      end
      default: begin
        busState_d = tmi_pkg::TMI_BUS_IDLE;
        prdata_d   = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busState_q <= tmi_pkg::TMI_BUS_IDLE;
      prdata     <= 32'h0000_0000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
    end else begin
      busState_q <= busState_d;
      prdata     <= prdata_d;
      pready     <= pready_d;
      pslverr    <= pslverr_d;
    end
  end

  // ========================================================================
  // configuration outputs
  // plain copies of config flops, so these pins never glitch
  always_comb begin
    fanOffFloat   = config_q[`TMI_CFG_FANOFF];
    dualDiodeMode = config_q[`TMI_CFG_DUALDIODE];
    polarityFlip  = config_q[`TMI_CFG_POLFLIP];
  end

endmodule

`default_nettype wire

// [verification/tmi_irq_top_asserts.sv]
// port-level checks of the thermal interrupt status and mask block
// assumes: bound into tmi_irq_top; mask is shadowed from apb writes
`timescale 1ns/100ps
`default_nettype none
`include "tmi_regs.svh"

module tmi_irq_asserts (
  input wire logic        clk,              // clock
  input wire logic        rst_n,            // reset, low
  input wire logic [11:0] paddr,            // address
  input wire logic        psel,             // select
  input wire logic        penable,          // access
  input wire logic        pwrite,           // direction
  input wire logic [31:0] pwdata,           // write data
  input wire logic [3:0]  pstrb,            // lanes
  input wire logic [31:0] prdata,           // read data
  input wire logic        pready,           // answer
  input wire logic        intTempLimitHit,  // event
  input wire logic        remote1LimitHit,  // event
  input wire logic        remote2LimitHit,  // event
  input wire logic        remote1FaultHit,  // event
  input wire logic        remote2FaultHit,  // event
  input wire logic        overtempOwnDrive, // own drive
  input wire logic        generalInputPin,  // pin
  input wire logic        overtempLineN,    // line, low
  input wire logic        polarityFlip,     // flip bit
  input wire logic        intN,             // interrupt, low
  input wire logic        irq               // interrupt, high
);
  localparam logic [11:0] A_CFG = `TMI_BYTE_ADDR(`TMI_IDX_CONFIG);
  localparam logic [11:0] A_ST  = `TMI_BYTE_ADDR(`TMI_IDX_STATUS);
  localparam logic [11:0] A_MK  = `TMI_BYTE_ADDR(`TMI_IDX_MASK);
  logic [7:0] maskQ;
  logic [7:0] maskD;
  logic       done;
  logic       wrDone;
  logic       quiet;
  assign done   = psel && penable && pready;
  assign wrDone = done && pwrite && pstrb[0];
  // a write in flight may move mask or flags under a check
  assign quiet  = !(done && pwrite);
  // ==========================================================================
  // mask shadow
  always_comb begin
    maskD = maskQ;
    if (wrDone && paddr == A_MK)
      maskD = pwdata[7:0] & `TMI_MASK_WR_BITS;
    if (wrDone && paddr == A_CFG && pwdata[`TMI_CFG_SOFTRST])
      maskD = `TMI_MASK_RESET;
  end
  always_ff @(posedge clk) begin
    if (!rst_n)
      maskQ <= `TMI_MASK_RESET;
    else
      maskQ <= maskD;
  end
  // ==========================================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_inttemp;
    intTempLimitHit && !maskQ[0] && quiet |-> ##2 !intN;
  endproperty
  a_inttemp: assert property (p_inttemp)
    else $error("internal limit event raised no interrupt");
  property p_rem2;
    (remote2LimitHit && !maskQ[1] || remote2FaultHit && !maskQ[2]) && quiet
      |=> ##1 irq;
  endproperty
  a_rem2: assert property (p_rem2)
    else $error("second remote event raised no interrupt");
  sequence s_rem1;
    (remote1LimitHit && !maskQ[5] || remote1FaultHit && !maskQ[7]) && quiet;
  endsequence
  property p_rem1;
    s_rem1 |-> ##2 (!intN && irq);
  endproperty
  a_rem1: assert property (p_rem1)
    else $error("first remote event raised no interrupt");
  property p_ovt;
    (!overtempLineN && !overtempOwnDrive && quiet)[*6] ##0 !maskQ[6]
      |-> ##1 !intN;
  endproperty
  a_ovt: assert property (p_ovt)
    else $error("outside overload raised no interrupt");
  property p_genin;
    ($stable(generalInputPin) && quiet)[*5]
      ##0 (generalInputPin ^ polarityFlip) && !maskQ[4] |-> ##1 !intN;
  endproperty
  a_genin: assert property (p_genin)
    else $error("asserted input level raised no interrupt");
  property p_masked;
    (maskQ == `TMI_MASK_WR_BITS)[*3] |-> intN;
  endproperty
  a_masked: assert property (p_masked)
    else $error("interrupt low with every source masked");
  property p_mask_rd;
    done && !pwrite && paddr == A_MK |-> prdata == {24'h00_0000, maskQ};
  endproperty
  a_mask_rd: assert property (p_mask_rd)
    else $error("mask read differs from written value");
  property p_st_rsvd;
    done && !pwrite && paddr == A_ST |-> prdata[31:8] == 24'h00_0000
      && !prdata[3];
  endproperty
  a_st_rsvd: assert property (p_st_rsvd)
    else $error("status reserved bits not zero");
endmodule

bind tmi_irq_top tmi_irq_asserts u_asserts (.clk, .rst_n, .paddr, .psel,
  .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .intTempLimitHit,
  .remote1LimitHit, .remote2LimitHit, .remote1FaultHit, .remote2FaultHit,
  .overtempOwnDrive, .generalInputPin, .overtempLineN, .polarityFlip,
  .intN, .irq);
`default_nettype wire

// [verification/tmi_host_model.sv]
// host model: apb master that runs single read and write register transfers
// assumes: one clock; the slave answers whenever it likes
`timescale 1ns/100ps
`default_nettype none

module tmi_host_model (
  input  wire logic        clk,     // clock
  output var  logic [11:0] paddr,   // address
  output var  logic        psel,    // select
  output var  logic        penable, // access
  output var  logic        pwrite,  // direction
  output var  logic [31:0] pwdata,  // write data
  output var  logic [3:0]  pstrb,   // lanes
  input  wire logic [31:0] prdata,  // read data
  input  wire logic        pready,  // answer
  input  wire logic        pslverr  // error
);
  initial begin
    paddr   = 12'h000;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'hF;
  end
  // ==========================================================================
  // one transfer; the request stands until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rq,
                      output logic re, input logic [3:0] s = 4'hF);
    @(posedge clk);
    psel    <= 1'b1;
    pstrb   <= s;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // stale data must not look valid after release
    pwdata  <= ~d;
  endtask
endmodule
`default_nettype wire

// [verification/test_tmi_irq_top.sv]
// self-checking bench of the thermal interrupt status and mask block
// assumes: host model drives apb; bench drives events and pins
`timescale 1ns/100ps
`default_nettype none
`include "tmi_regs.svh"

module test_tmi_irq_top;
  localparam logic [11:0] CFG = `TMI_BYTE_ADDR(`TMI_IDX_CONFIG);
  localparam logic [11:0] ST  = `TMI_BYTE_ADDR(`TMI_IDX_STATUS);
  localparam logic [11:0] MK  = `TMI_BYTE_ADDR(`TMI_IDX_MASK);
  localparam logic [11:0] MIR = `TMI_BYTE_ADDR(`TMI_IDX_MIRROR);
  localparam logic [11:0] BAD = 12'h200;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  ev = 5'h00;
  logic        ownDrv = 1'b0;
  logic        pin = 1'b0;
  logic        ovtN = 1'b1;
  logic [11:0] paddr;
  logic        psel, penable, pwrite, pready, pslverr, intN, irq, e;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic        fanOff, dual, flip;
  int          mismatches = 0, checks = 0, cycles = 0, r;
  int          modelSt = 0, modelMk = 0, modelCf = 'h20;

  always #50 clk = ~clk;
  tmi_host_model u_host (.clk, .paddr, .psel, .penable, .pwrite, .pwdata,
    .pstrb, .prdata, .pready, .pslverr);
  tmi_irq_top u_dut (.clk, .rst_n, .paddr, .psel, .penable, .pwrite,
    .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .intTempLimitHit(ev[0]), .remote2LimitHit(ev[1]),
    .remote2FaultHit(ev[2]), .remote1LimitHit(ev[3]),
    .remote1FaultHit(ev[4]), .overtempOwnDrive(ownDrv),
    .generalInputPin(pin), .overtempLineN(ovtN), .intN, .irq,
    .fanOffFloat(fanOff), .dualDiodeMode(dual), .polarityFlip(flip));

  // ==========================================================================
  // model and checks
  function automatic int map(input logic [4:0] v);
    return int'({v[4], 1'b0, v[3], 2'b00, v[2:0]});
  endfunction
  // conditions still present re-set their flag after a clear
  function automatic int live();
    return map(ev) | (int'(!ovtN && !ownDrv) << 6);
  endfunction
  function automatic int expSt();
    return modelSt | (((int'(pin) ^ (modelCf >> 6)) & 1) << 4);
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input int d,
                    input logic [3:0] s = 4'hF);
    u_host.xfer(1'b1, a, d, q, e, s);
    if (!s[0])
      return;
    if (a == MK)
      modelMk = d & 'hF7;
    if (a == ST)
      modelSt = (modelSt & ~d) | live();
    if (a == CFG)
      modelCf = d & 'hEF;
    if (a == CFG && d[4]) begin
      modelCf = 'h20;
      modelSt = 0;
      modelMk = 0;
    end
  endtask
  task automatic rd(input logic [11:0] a, input int x);
    u_host.xfer(1'b0, a, 32'h0000_0000, q, e);
    cmp(q, x);
    cmp(32'(e), 32'(a == BAD));
  endtask
  task automatic chkInt();
    logic e0;
    repeat (2) @(posedge clk);
    e0 = ((expSt() & ~modelMk & 'hF7) == 0);
    cmp(32'(intN), 32'(e0));
    cmp(32'(irq), 32'(!e0));
  endtask
  task automatic chkCfg();
    @(posedge clk);
    cmp(32'({dual, flip, fanOff}), 32'((modelCf >> 5) & 7));
  endtask
  task automatic pulse(input logic [4:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 5'h00;
    modelSt |= map(v);
    repeat (3) @(posedge clk);
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ==========================================================================
  // tests
  initial begin
    r = $urandom(9472);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(CFG, 'h20);
    rd(MK, 0);
    rd(ST, expSt());
    wr(MIR, 'hFF);
    rd(MIR, expSt());
    rd(BAD, 0);
    chkInt();
    $display("test reset done");
    for (int k = 0; k < 12; k++) begin
      pulse(k < 5 ? 5'(1 << k) : 5'($urandom));
      rd(ST, expSt());
      chkInt();
      wr(MK, $urandom & 'hFF);
      chkInt();
      wr(ST, $urandom & 'hFF);
      rd(MIR, expSt());
    end
    wr(ST, 'hFF);
    wr(MK, 0);
    $display("test events done");
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    rd(ST, expSt());
    rd(ST, expSt());
    wr(CFG, 'h60);
    rd(ST, expSt());
    chkCfg();
    pin <= 1'b0;
    repeat (4) @(posedge clk);
    rd(ST, expSt());
    chkInt();
    wr(CFG, 'h80);
    $display("test input done");
    ownDrv <= 1'b1;
    ovtN <= 1'b0;
    repeat (6) @(posedge clk);
    rd(ST, expSt());
    modelCf |= 'h20;
    rd(CFG, modelCf);
    chkCfg();
    ownDrv <= 1'b0;
    repeat (6) @(posedge clk);
    modelSt |= 'h40;
    rd(ST, expSt());
    chkInt();
    ovtN <= 1'b1;
    repeat (4) @(posedge clk);
    wr(ST, 'h40);
    rd(ST, expSt());
    $display("test overload done");
    ev <= 5'h10;
    modelSt |= 'h80;
    repeat (4) @(posedge clk);
    wr(ST, 'h80);
    rd(ST, expSt());
    wr(MK, 'h80);
    chkInt();
    ev <= 5'h00;
    wr(ST, 'h80);
    wr(MK, 0);
    chkInt();
    $display("test repeating error done");
    wr(MK, 'hFF);
    rd(MK, modelMk);
    wr(MK, 'h00, 4'hE);
    rd(MK, modelMk);
    pulse(5'h01);
    wr(CFG, 'h5F);
    rd(CFG, 'h20);
    chkCfg();
    rd(MK, 0);
    rd(ST, expSt());
    chkInt();
    $display("test restore done");
    wrap_up();
  end
endmodule
`default_nettype wire
